// [logic/cbs_pkg.sv]
// Purpose: shared constants and helpers of the charge bank state sequencer
// Assumes: four charge banks, bit 0 is bank A, bit 3 is bank D
// Notes: regulator states 0-3 are boost, 4-8 are float
package cbs_pkg;

    localparam int unsigned CBS_CLK_HZ = 250_000_000;
    localparam int unsigned CBS_TICK_S = 1;
    localparam int unsigned CBS_TICK_CYC = CBS_CLK_HZ * CBS_TICK_S;

    localparam int CBS_NUM_BANKS = 4;
    localparam int CBS_NUM_ALARMS = 7;
    localparam int CBS_SYNC_W = CBS_NUM_ALARMS + 3;

    localparam logic [3:0] CBS_ST_RESET = 4'h0;
    localparam logic [3:0] CBS_ST_FLOAT = 4'h4;
    localparam logic [3:0] CBS_ST_LAST = 4'h8;

    localparam logic [3:0] CBS_BANK_ALL = 4'hF;
    localparam logic [3:0] CBS_BANK_NONE = 4'h0;
    localparam logic [3:0] CBS_BANK_A = 4'h1;

    localparam logic [7:0] CBS_DELAY_RST = 8'h00;
    localparam logic [7:0] CBS_EE_PATTERN = 8'hA5;

    // hardware test step numbers
    localparam logic [4:0] CBS_TS_CHG = 5'h00;
    localparam logic [4:0] CBS_TS_LOAD = 5'h01;
    localparam logic [4:0] CBS_TS_EE_WR = 5'h02;
    localparam logic [4:0] CBS_TS_EE_RD = 5'h03;
    localparam logic [4:0] CBS_TS_BANK_A = 5'h04;
    localparam logic [4:0] CBS_TS_BANK_D = 5'h07;
    localparam logic [4:0] CBS_TS_REG0 = 5'h08;
    localparam logic [4:0] CBS_TS_REG8 = 5'h10;
    localparam logic [4:0] CBS_TS_SERIAL = 5'h11;

    typedef enum logic [2:0] {
        KP_IDLE,
        KP_MA,
        KP_INC1,
        KP_INC2,
        KP_TEST
    } cbs_kp_t;

    // banks switched on in each regulator state
    function automatic logic [3:0] cbs_bank_map(input logic [3:0] st);
        case (st)
            4'h0: cbs_bank_map = 4'hF;
            4'h1: cbs_bank_map = 4'h7;
            4'h2: cbs_bank_map = 4'h3;
            4'h3: cbs_bank_map = 4'h1;
            4'h5: cbs_bank_map = 4'h1;
            4'h6: cbs_bank_map = 4'h3;
            4'h7: cbs_bank_map = 4'h7;
            4'h8: cbs_bank_map = 4'hF;
            default: cbs_bank_map = 4'h0;
        endcase
    endfunction : cbs_bank_map

endpackage : cbs_pkg

// [logic/cbs_in_sync.sv]
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk_sys
// Notes: output changes only when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module cbs_in_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output var logic [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                s1_q[i] <= 1'b0;
                s2_q[i] <= 1'b0;
                s3_q[i] <= 1'b0;
                dout[i] <= 1'b0;
            end else begin
                s1_q[i] <= din[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                // one-cycle glitch past stage one is filtered here
                if (s2_q[i] == s3_q[i]) begin
                    dout[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : cbs_in_sync
`default_nettype wire

// [logic/cbs_sequencer.sv]
// Purpose: charge bank state sequencer with keypad hardware test
// Assumes: volt_high/volt_low and eeprom read data come from clk_sys logic
// Notes: keys and alarm contacts are pins and are synchronised
// Notes on behaviour
// - regulator holds exactly one of nine states, each a bank pattern
// - reset enters state 0 with all banks on
// - next state follows present state and measured battery voltage
// - boost states 0-3 change only after the state-change delay
// - float states 4-8 change at most once per second
// - from state 0 toward 4 banks switch off singly, D first
// - seven alarm inputs form one byte, input 1 at bit 0
// - an alarm bit reads one while the alarm is active
// - increment press freezes the test cycle, next press resumes it
// - decrement press ends the test, normal operation resumes
// - test drives banks A, B, C, D singly and shows each
// - test cycles charge, load, eeprom check, all states, serial send
// - alarm active when its normally closed contact opens
`timescale 1ns/10ps
`default_nettype none
module cbs_sequencer
    import cbs_pkg::*;
#(
    parameter int unsigned TICK_CYC = CBS_TICK_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic volt_high,
    input wire logic volt_low,
    input wire logic [7:0] delay_s,
    input wire logic key_meter_adj,
    input wire logic key_inc,
    input wire logic decrement_key,
    input wire logic [CBS_NUM_ALARMS-1:0] alarm_pin,
    input wire logic ee_rd_valid,
    input wire logic [7:0] ee_rd_data,
    output logic [3:0] bank_on_q,
    output logic [3:0] reg_state_q,
    output logic charge_sw_q,
    output logic load_sw_q,
    output logic test_active_q,
    output logic test_paused_q,
    output logic ee_wr_q,
    output logic ee_rd_q,
    output logic [7:0] ee_wdata_q,
    output logic ee_pass_q,
    output logic ee_fail_q,
    output logic ser_tx_q,
    output logic [3:0] disp_bank_q,
    output logic [7:0] alarm_byte_q
);
    localparam int TW = $clog2(TICK_CYC + 1);
    default clocking cbs_cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // pins and one-second tick
    logic [CBS_SYNC_W-1:0] sync_lvl;
    logic [2:0] key_prev_q;
    logic ma_press;
    logic inc_press;
    logic dec_press;
    logic [TW-1:0] tick_cnt_q;
    logic tick_q;
    cbs_in_sync #(.W(CBS_SYNC_W)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .din({decrement_key, key_inc, key_meter_adj, alarm_pin}),
        .dout(sync_lvl)
    );
    assign ma_press = sync_lvl[CBS_NUM_ALARMS] & ~key_prev_q[0];
    assign inc_press = sync_lvl[CBS_NUM_ALARMS+1] & ~key_prev_q[1];
    assign dec_press = sync_lvl[CBS_NUM_ALARMS+2] & ~key_prev_q[2];
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            key_prev_q <= 3'h0;
        end else begin
            key_prev_q <= sync_lvl[CBS_SYNC_W-1:CBS_NUM_ALARMS];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == TW'(TICK_CYC - 1));
            if (tick_cnt_q == TW'(TICK_CYC - 1)) begin
                tick_cnt_q <= '0;
            end else begin
                tick_cnt_q <= tick_cnt_q + TW'(1);
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            alarm_byte_q <= 8'h00;
        end else begin
            alarm_byte_q <= {1'b0, sync_lvl[CBS_NUM_ALARMS-1:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // keypad entry and test mode
    cbs_kp_t kp_q;
    cbs_kp_t kp_d;
    logic [4:0] ts_q;
    logic [4:0] ts_d;
    logic tick_adv;
    always_comb begin
        kp_d = kp_q;
        case (kp_q)
            KP_IDLE: if (ma_press) kp_d = KP_MA;
            KP_MA: if (inc_press) kp_d = KP_INC1;
                   else if (ma_press || dec_press) kp_d = KP_IDLE;
            KP_INC1: if (inc_press) kp_d = KP_INC2;
                     else if (ma_press || dec_press) kp_d = KP_IDLE;
            KP_INC2: if (ma_press) kp_d = KP_TEST;
                     else if (inc_press || dec_press) kp_d = KP_IDLE;
            KP_TEST: if (dec_press) kp_d = KP_IDLE;
            default: kp_d = KP_IDLE;
        endcase
    end
    assign tick_adv = test_active_q && !test_paused_q && tick_q;
    always_comb begin
        ts_d = ts_q;
        if (kp_q != KP_TEST) begin
            ts_d = CBS_TS_CHG;
        end else if (tick_adv) begin
            ts_d = (ts_q == CBS_TS_SERIAL) ? CBS_TS_CHG : ts_q + 5'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            kp_q <= KP_IDLE;
            test_active_q <= 1'b0;
            ts_q <= CBS_TS_CHG;
        end else begin
            kp_q <= kp_d;
            test_active_q <= (kp_d == KP_TEST);
            ts_q <= ts_d;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst || kp_q != KP_TEST) begin
            test_paused_q <= 1'b0;
        end else if (inc_press) begin
            test_paused_q <= ~test_paused_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // regulator state
    logic [3:0] reg_state_d;
    logic [7:0] dly_cnt_q;
    logic [3:0] test_banks;
    logic [3:0] ts_reg;
    assign ts_reg = 4'(ts_d - CBS_TS_REG0);
    // voltage and state pick the next state
    always_comb begin
        reg_state_d = reg_state_q;
        if (kp_q == KP_TEST) begin
            reg_state_d = (kp_d == KP_TEST) ? reg_state_q : CBS_ST_RESET;
            if (kp_d == KP_TEST && ts_d >= CBS_TS_REG0 && ts_d <= CBS_TS_REG8) begin
                reg_state_d = ts_reg;
            end
        end else if (reg_state_q < CBS_ST_FLOAT) begin
            if (tick_q && dly_cnt_q >= delay_s) begin
                if (volt_high) begin
                    reg_state_d = reg_state_q + 4'h1;
                end else if (volt_low && reg_state_q != CBS_ST_RESET) begin
                    reg_state_d = reg_state_q - 4'h1;
                end
            end
        end else if (tick_q) begin
            if (volt_high && reg_state_q != CBS_ST_FLOAT) begin
                reg_state_d = reg_state_q - 4'h1;
            end else if (volt_low && reg_state_q != CBS_ST_LAST) begin
                reg_state_d = reg_state_q + 4'h1;
            end
        end
    end
    // delay counts whole seconds spent in the present state
    always_ff @(posedge clk_sys) begin
        if (rst || reg_state_d != reg_state_q) begin
            dly_cnt_q <= CBS_DELAY_RST;
        end else if (tick_q && dly_cnt_q != 8'hFF) begin
            dly_cnt_q <= dly_cnt_q + 8'h01;
        end
    end
    // banks one by one in test
    always_comb begin
        test_banks = CBS_BANK_NONE;
        if (ts_d >= CBS_TS_BANK_A && ts_d <= CBS_TS_BANK_D) begin
            test_banks = CBS_BANK_A << ts_d[1:0];
        end else if (ts_d >= CBS_TS_REG0 && ts_d <= CBS_TS_REG8) begin
            test_banks = cbs_bank_map(ts_reg);
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_state_q <= CBS_ST_RESET;
            bank_on_q <= CBS_BANK_ALL;
            disp_bank_q <= CBS_BANK_NONE;
        end else begin
            reg_state_q <= reg_state_d;
            // map drops the highest bank first
            bank_on_q <= (kp_d == KP_TEST) ? test_banks : cbs_bank_map(reg_state_d);
            disp_bank_q <= (kp_d == KP_TEST && ts_d >= CBS_TS_BANK_A &&
                            ts_d <= CBS_TS_BANK_D) ? test_banks : CBS_BANK_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // test side effects: switches, eeprom, serial
    logic step_in;
    assign step_in = (kp_d == KP_TEST) && (ts_d != ts_q);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            charge_sw_q <= 1'b1;
            load_sw_q <= 1'b1;
            ee_wr_q <= 1'b0;
            ee_rd_q <= 1'b0;
            ser_tx_q <= 1'b0;
            ee_wdata_q <= 8'h00;
        end else begin
            charge_sw_q <= 1'b1;
            load_sw_q <= (kp_d != KP_TEST) || (ts_d != CBS_TS_CHG);
            ee_wr_q <= step_in && ts_d == CBS_TS_EE_WR;
            ee_rd_q <= step_in && ts_d == CBS_TS_EE_RD;
            ser_tx_q <= step_in && ts_d == CBS_TS_SERIAL;
            ee_wdata_q <= CBS_EE_PATTERN;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ee_pass_q <= 1'b0;
            ee_fail_q <= 1'b0;
        end else if (test_active_q && ee_rd_valid) begin
            ee_pass_q <= (ee_rd_data == CBS_EE_PATTERN);
            ee_fail_q <= (ee_rd_data != CBS_EE_PATTERN);
        end else if (ee_wr_q) begin
            ee_pass_q <= 1'b0;
            ee_fail_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_state_range: assert property (reg_state_q <= CBS_ST_LAST)
        else $error("regulator state out of range");
    a_reset_entry: assert property ($past(rst) |->
        reg_state_q == CBS_ST_RESET && bank_on_q == CBS_BANK_ALL) else $error("reset state wrong");
    a_bank_pattern: assert property (!test_active_q |->
        bank_on_q == cbs_bank_map(reg_state_q)) else $error("banks do not match state");
    a_boost_delay: assert property (!test_active_q && reg_state_q < CBS_ST_FLOAT &&
        reg_state_d != reg_state_q |-> tick_q && dly_cnt_q >= delay_s)
        else $error("boost moved early");
    a_float_tick: assert property (!test_active_q && reg_state_q >= CBS_ST_FLOAT &&
        reg_state_d != reg_state_q |-> tick_q) else $error("float moved off tick");
    a_bank_d_first: assert property (!test_active_q && kp_d != KP_TEST &&
        reg_state_q < CBS_ST_FLOAT && reg_state_d == reg_state_q + 4'h1 |=>
        bank_on_q == ($past(bank_on_q) >> 1)) else $error("bank switched off out of order");
    a_alarm_byte: assert property (##1 alarm_byte_q ==
        {1'b0, $past(sync_lvl[CBS_NUM_ALARMS-1:0])}) else $error("alarm byte mismatch");
    a_pause_hold: assert property (test_active_q && test_paused_q && !dec_press |=>
        $stable(ts_q)) else $error("test moved while paused");
    a_dec_exit: assert property (test_active_q && dec_press |=> !test_active_q &&
        reg_state_q == CBS_ST_RESET) else $error("decrement did not end test");
    a_bank_walk: assert property (tick_adv && !dec_press && ts_q == CBS_TS_BANK_A |=>
        bank_on_q == 4'h2 && disp_bank_q == 4'h2) else $error("bank B not next");
    a_single_step: assert property (!test_active_q |-> reg_state_d == reg_state_q ||
        reg_state_d == reg_state_q + 4'h1 || reg_state_d + 4'h1 == reg_state_q)
        else $error("state jumped");
    a_ee_verdict: assert property (test_active_q && ee_rd_valid &&
        ee_rd_data == CBS_EE_PATTERN |=> ee_pass_q && !ee_fail_q)
        else $error("eeprom pass not shown");

    c_test_on: cover property ($rose(test_active_q));
    c_paused: cover property ($rose(test_paused_q));
    c_float: cover property (!test_active_q && reg_state_q == CBS_ST_FLOAT);
    c_ee_pass: cover property ($rose(ee_pass_q));
endmodule : cbs_sequencer
`default_nettype wire

// [tb/cbs_far_side.sv]
// Purpose: eeprom partner beside the sequencer hardware test
// Assumes: one read outstanding at a time
// Notes: slow adds wait cycles, bad corrupts the read-back
`timescale 1ns/10ps
`default_nettype none
module cbs_far_side (
    input wire logic clk_sys,
    input wire logic ee_wr,
    input wire logic ee_rd,
    input wire logic [7:0] ee_wdata,
    input wire logic slow,
    input wire logic bad,
    output wire logic ee_rd_valid,
    output wire logic [7:0] ee_rd_data
);
    logic [7:0] mem_q = 8'h00;
    logic valid_q = 1'b0;
    logic [7:0] data_q = 8'h00;
    int wait_q = -1;

    assign ee_rd_valid = valid_q;
    assign ee_rd_data = data_q;

    ////////////////////////////////////////////////////////////////////////
    // write then read-back
    always @(posedge clk_sys) begin
        valid_q <= 1'b0;
        // data is not held past the valid cycle, so stale bytes cannot pass
        data_q <= ~data_q;
        if (ee_wr) mem_q <= ee_wdata;
        if (wait_q > 0) wait_q <= wait_q - 1;
        if (wait_q == 0) begin
            valid_q <= 1'b1;
            data_q <= bad ? ~mem_q : mem_q;
            wait_q <= -1;
        end
        if (ee_rd) wait_q <= slow ? 6 : 0;
    end
endmodule : cbs_far_side
`default_nettype wire

// [tb/charge_bank_state_sequencer_bench.sv]
// Purpose: self-checking bench of the charge bank state sequencer
// Assumes: short tick of TICK clocks stands for one second
// Notes: inputs change on the falling edge only
`timescale 1ns/10ps
`default_nettype none
module charge_bank_state_sequencer_bench;
    import cbs_pkg::*;
    localparam int TICK = 10;
    logic clk_sys, rst, volt_high, volt_low, key_meter_adj, key_inc, decrement_key;
    logic ee_rd_valid, slow, bad;
    logic [7:0] delay_s, ee_rd_data, ee_wdata_q, alarm_byte_q;
    logic [6:0] alarm_pin;
    logic [3:0] bank_on_q, reg_state_q, disp_bank_q;
    logic charge_sw_q, load_sw_q, test_active_q, test_paused_q, ee_wr_q, ee_rd_q;
    logic ee_pass_q, ee_fail_q, ser_tx_q;
    logic [3:0] bmap [9] = '{4'hF, 4'h7, 4'h3, 4'h1, 4'h0, 4'h1, 4'h3, 4'h7, 4'hF};
    int n_mismatch = 0;
    int checks_done = 0;

    cbs_sequencer #(.TICK_CYC(TICK)) cbs_sequencer_inst (.clk_sys(clk_sys), .rst(rst),
        .volt_high(volt_high), .volt_low(volt_low), .delay_s(delay_s),
        .key_meter_adj(key_meter_adj), .key_inc(key_inc), .decrement_key(decrement_key),
        .alarm_pin(alarm_pin), .ee_rd_valid(ee_rd_valid), .ee_rd_data(ee_rd_data),
        .bank_on_q(bank_on_q), .reg_state_q(reg_state_q), .charge_sw_q(charge_sw_q),
        .load_sw_q(load_sw_q), .test_active_q(test_active_q), .test_paused_q(test_paused_q),
        .ee_wr_q(ee_wr_q), .ee_rd_q(ee_rd_q), .ee_wdata_q(ee_wdata_q), .ee_pass_q(ee_pass_q),
        .ee_fail_q(ee_fail_q), .ser_tx_q(ser_tx_q), .disp_bank_q(disp_bank_q),
        .alarm_byte_q(alarm_byte_q));

    cbs_far_side cbs_far_side_inst (.clk_sys(clk_sys), .ee_wr(ee_wr_q), .ee_rd(ee_rd_q),
        .ee_wdata(ee_wdata_q), .slow(slow), .bad(bad), .ee_rd_valid(ee_rd_valid),
        .ee_rd_data(ee_rd_data));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // key held long enough to clear the synchroniser and edge detector
    task automatic press(input int k);
        if (k == 0) key_meter_adj = 1'b1;
        if (k == 1) key_inc = 1'b1;
        if (k == 2) decrement_key = 1'b1;
        repeat (8) @(negedge clk_sys);
        key_meter_adj = 1'b0;
        key_inc = 1'b0;
        decrement_key = 1'b0;
        repeat (8) @(negedge clk_sys);
    endtask : press

    task automatic wait_state(output int cyc);
        logic [3:0] prev;
        prev = reg_state_q;
        for (cyc = 0; cyc < 2000 && reg_state_q === prev; cyc++) @(negedge clk_sys);
    endtask : wait_state

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk("state", 8'h00, 8'(reg_state_q));
        chk("banks", 8'h0F, 8'(bank_on_q));
        chk("test", 8'h00, 8'(test_active_q));
        $display("test reset done");
    endtask : t_reset

    task automatic t_alarm;
        for (int i = 0; i < 8; i++) begin
            alarm_pin = (i == 7) ? 7'h7F : 7'(1 << i);
            repeat (8) @(negedge clk_sys);
            chk("alarm byte", {1'b0, alarm_pin}, alarm_byte_q);
        end
        alarm_pin = 7'h00;
        repeat (8) @(negedge clk_sys);
        chk("alarm clear", 8'h00, alarm_byte_q);
        $display("test alarm done");
    endtask : t_alarm

    task automatic t_boost;
        int cyc;
        delay_s = 8'h03;
        volt_high = 1'b1;
        for (int s = 1; s <= 4; s++) begin
            wait_state(cyc);
            chk("boost state", 8'(s), 8'(reg_state_q));
            chk("boost banks", 8'(bmap[s]), 8'(bank_on_q));
            if (s > 1) chk("boost gap ok", 8'h01, 8'(cyc > 2 * TICK && cyc <= 5 * TICK));
        end
        $display("test boost done");
    endtask : t_boost

    task automatic t_float;
        int cyc;
        volt_high = 1'b0;
        volt_low = 1'b1;
        for (int s = 5; s <= 8; s++) begin
            wait_state(cyc);
            chk("float state", 8'(s), 8'(reg_state_q));
            chk("float banks", 8'(bmap[s]), 8'(bank_on_q));
            if (s > 5) chk("float gap", 8'(TICK), 8'(cyc));
        end
        repeat (3 * TICK) @(negedge clk_sys);
        chk("float top", 8'h08, 8'(reg_state_q));
        volt_low = 1'b0;
        volt_high = 1'b1;
        wait_state(cyc);
        chk("float down", 8'h07, 8'(reg_state_q));
        volt_high = 1'b0;
        $display("test float done");
    endtask : t_float

    task automatic t_hwtest;
        int n;
        logic [3:0] held;
        press(0);
        press(1);
        press(1);
        press(0);
        chk("test on", 8'h01, 8'(test_active_q));
        for (n = 0; n < 40 && ee_wr_q !== 1'b1; n++) @(negedge clk_sys);
        chk("ee write", 8'h01, 8'(ee_wr_q));
        chk("ee pattern", CBS_EE_PATTERN, ee_wdata_q);
        for (n = 0; n < 40 && ee_pass_q !== 1'b1; n++) @(negedge clk_sys);
        chk("ee verdict", 8'h01, {ee_fail_q, ee_pass_q});
        for (int b = 0; b < 4; b++) begin
            for (n = 0; n < 3 * TICK && disp_bank_q !== 4'(1 << b); n++) @(negedge clk_sys);
            chk("bank shown", 8'(1 << b), 8'(disp_bank_q));
            chk("bank alone", 8'(1 << b), 8'(bank_on_q));
        end
        press(1);
        chk("paused", 8'h01, 8'(test_paused_q));
        held = bank_on_q;
        repeat (4 * TICK) @(negedge clk_sys);
        chk("frozen", 8'(held), 8'(bank_on_q));
        press(1);
        chk("resumed", 8'h00, 8'(test_paused_q));
        for (int s = 0; s < 9; s++) begin
            for (n = 0; n < 4 * TICK && reg_state_q !== 4'(s); n++) @(negedge clk_sys);
            chk("test banks", 8'(bmap[s]), 8'(bank_on_q));
        end
        for (n = 0; n < 4 * TICK && ser_tx_q !== 1'b1; n++) @(negedge clk_sys);
        chk("serial sent", 8'h01, 8'(ser_tx_q));
        for (n = 0; n < 2 * TICK && load_sw_q !== 1'b0; n++) @(negedge clk_sys);
        chk("load off", 8'h00, 8'(load_sw_q));
        chk("charge on", 8'h01, 8'(charge_sw_q));
        slow = 1'b1;
        bad = 1'b1;
        for (n = 0; n < 2 * TICK && load_sw_q !== 1'b1; n++) @(negedge clk_sys);
        chk("load on", 8'h01, 8'(load_sw_q));
        for (n = 0; n < 4 * TICK && ee_rd_q !== 1'b1; n++) @(negedge clk_sys);
        chk("ee read", 8'h01, 8'(ee_rd_q));
        for (n = 0; n < 30 * TICK && ee_fail_q !== 1'b1; n++) @(negedge clk_sys);
        chk("ee bad verdict", 8'h02, {ee_fail_q, ee_pass_q});
        press(2);
        chk("test off", 8'h00, 8'(test_active_q));
        chk("exit state", 8'h00, 8'(reg_state_q));
        chk("exit banks", 8'h0F, 8'(bank_on_q));
        $display("test hardware test done");
    endtask : t_hwtest

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, volt_high, volt_low, key_meter_adj, key_inc, decrement_key} = 6'h20;
        {slow, bad} = 2'h0;
        delay_s = CBS_DELAY_RST;
        alarm_pin = 7'h00;
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        t_reset();
        t_alarm();
        t_boost();
        t_float();
        t_hwtest();
        give_verdict();
    end

    // all tests need about 650 cycles; thirty times that means a hang
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        give_verdict();
    end
endmodule : charge_bank_state_sequencer_bench
`default_nettype wire
